// file: hdl/ssc_consts.svh
/*
  Constants of the serial switch control shifter: register offsets,
  field positions, reset values and widths.
  Assumes inclusion by bare name from the package and the design file.
*/
// Behaviour
// - Select low: sample data on clock rise
// - Eight-bit register, one bit per switch
// - Output last stage on falling clock edges
// - First-shifted bit enters and leaves first
// - Shifting never alters the switches
// - Select rise copies register into latch
// - Select high: clock and data ignored
// - Select high: output holds first-shifted bit
// - Register keeps the last eight bits
// - Reset pin low clears register and switches
// - Power-up: register zero, switches open
// - Latched one closes switch, zero opens
// - Switches act independently, any combination
// - Daisy chain shares select, latches together
// - Dual variant maps bits onto two banks
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

`define SSC_WORD_BITS   8
`define SSC_SYNC_STAGES 2
`define SSC_ADDR_BITS   12
`define SSC_CTRL_OFF    12'h000
`define SSC_SHIFT_OFF   12'h004
`define SSC_LATCH_OFF   12'h008
`define SSC_CTRL_DUAL   0
`define SSC_CTRL_RST    32'h0000_0000
`define SSC_WORD_RST    8'h00
// Idle pin levels {reset_n, cs_n, sclk, din}
`define SSC_PIN_IDLE    4'hC

`endif

// file: hdl/ssc_pkg.sv
/*
  Types of the serial switch control shifter.
  Assumes ssc_consts.svh on the include path.
*/
`include "ssc_consts.svh"

package ssc_pkg;

  typedef logic [`SSC_WORD_BITS-1:0] ssc_word_type;

  // Pin levels after the synchroniser
  typedef struct packed {
    logic reset_n;
    logic cs_n;
    logic sclk;
    logic din;
  } ssc_pins_type;

  typedef struct packed {
    logic dual;
  } ssc_ctrl_type;

endpackage

// file: hdl/ssc_shifter.sv
/*
  Serial control logic of an eight-switch multiplexer, with an APB slave
  for configuration and status.
  Assumes serial pins arrive asynchronously and toggle slowly compared
  with CLOCK (serial clock period at least eight CLOCK periods).
*/
`timescale 1ns/100ps
`include "ssc_consts.svh"

module ssc_shifter (
  input  wire logic                      CLOCK,
  input  wire logic                      SYS_RST,
  input  wire logic                      CS_N,
  input  wire logic                      SCLK,
  input  wire logic                      DIN,
  input  wire logic                      RESET_N,
  output      logic                      DOUT,
  output      logic [`SSC_WORD_BITS-1:0] SWITCH_CLOSED,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [`SSC_ADDR_BITS-1:0] PADDR,
  input  wire logic [31:0]               PWDATA,
  output      logic [31:0]               PRDATA,
  output      logic                      PREADY,
  output      logic                      PSLVERR
);

  localparam int NPIN = $bits(ssc_pkg::ssc_pins_type);
  // Synchronisers start at the idle pin levels, so no false edge follows reset
  localparam ssc_pkg::ssc_pins_type PIN_IDLE = ssc_pkg::ssc_pins_type'(`SSC_PIN_IDLE);

  // Switch outputs per variant: in dual mode [7:4] is the second bank
  // switches 3..0 and [3:0] the first bank switches 3..0.
  function automatic ssc_pkg::ssc_word_type map_switches(
    input ssc_pkg::ssc_word_type w,
    input logic                  dual
  );
    ssc_pkg::ssc_word_type m;
    m = w;
    if (dual) begin
      m[7:4] = {w[4], w[5], w[6], w[7]};
      m[3:0] = w[3:0];
    end
    return m;
  endfunction

  // One decode serves the error flag and its check, so the two agree
  function automatic logic reg_mapped(input logic [`SSC_ADDR_BITS-1:0] a);
    return (a == `SSC_CTRL_OFF) || (a == `SSC_SHIFT_OFF) || (a == `SSC_LATCH_OFF);
  endfunction

  ssc_pkg::ssc_pins_type raw_pins;
  logic [NPIN-1:0]       sync_a;
  logic [NPIN-1:0]       sync_b;
  ssc_pkg::ssc_pins_type pins;
  ssc_pkg::ssc_pins_type pins_d;
  ssc_pkg::ssc_word_type shift;
  ssc_pkg::ssc_word_type latch;
  ssc_pkg::ssc_ctrl_type ctrl;
  logic                  clr;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  cs_rise;
  logic                  setup_phase;
  logic                  access_phase;
  logic                  addr_ok;
  logic [3:0]            rise_count;

  assign raw_pins = '{reset_n: RESET_N, cs_n: CS_N, sclk: SCLK, din: DIN};

  // Two flip-flops per pin; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          sync_a[g] <= PIN_IDLE[g];
          sync_b[g] <= PIN_IDLE[g];
        end else begin
          sync_a[g] <= raw_pins[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  assign pins = ssc_pkg::ssc_pins_type'(sync_b);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST)
      pins_d <= PIN_IDLE;
    else
      pins_d <= pins;
  end

  // Reset pin wins over every shift and latch event
  assign clr       = ~pins.reset_n;
  assign sclk_rise = pins.sclk & ~pins_d.sclk & ~pins.cs_n;
  assign sclk_fall = ~pins.sclk & pins_d.sclk & ~pins.cs_n;
  assign cs_rise   = pins.cs_n & ~pins_d.cs_n;

  // Shift register; it holds the last eight bits however many clocks came
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || clr)
      shift <= `SSC_WORD_RST;
    else if (sclk_rise)
      shift <= {shift[`SSC_WORD_BITS-2:0], pins.din};
  end

  // Rises seen in the current select-low period, stuck at 15; only the
  // checks read it, to show frames longer than eight clocks
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || clr || pins.cs_n)
      rise_count <= 4'h0;
    else if (sclk_rise && rise_count != 4'hF)
      rise_count <= rise_count + 4'h1;
  end

  // Last stage moves to the pin on falling edges only; with select high
  // no edge is seen, so the first-shifted bit stays on the pin.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || clr)
      DOUT <= 1'h0;
    else if (sclk_fall)
      DOUT <= shift[`SSC_WORD_BITS-1];
  end

  // Latch changes only on the select rise or a reset, regardless of the clock level
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || clr)
      latch <= `SSC_WORD_RST;
    else if (cs_rise)
      latch <= shift;
  end

  // One bit per switch, each independent; a one closes the switch
  always_ff @(posedge CLOCK) begin
    if (SYS_RST)
      SWITCH_CLOSED <= `SSC_WORD_RST;
    else
      SWITCH_CLOSED <= map_switches(latch, ctrl.dual);
  end

  // APB slave: zero wait states, read data prepared in the setup cycle
  assign setup_phase  = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign PREADY       = 1'h1;
  assign addr_ok      = reg_mapped(PADDR);

  always_ff @(posedge CLOCK) begin
    if (SYS_RST)
      ctrl <= ssc_pkg::ssc_ctrl_type'(1'(`SSC_CTRL_RST));
    else if (access_phase && PWRITE && PADDR == `SSC_CTRL_OFF)
      ctrl.dual <= PWDATA[`SSC_CTRL_DUAL];
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'h0;
    end else if (setup_phase) begin
      PSLVERR <= ~addr_ok;
      case (PADDR)
        `SSC_CTRL_OFF:  PRDATA <= {31'h0000_0000, ctrl.dual};
        `SSC_SHIFT_OFF: PRDATA <= {24'h00_0000, shift};
        `SSC_LATCH_OFF: PRDATA <= {24'h00_0000, latch};
        default:        PRDATA <= 32'h0000_0000;
      endcase
    end else if (!PSEL) begin
      PSLVERR <= 1'h0;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_shift_on_rise: assert property (sclk_rise && !clr |=>
    shift == {$past(shift[6:0]), $past(pins.din)})
    else $error("shift register did not take data on clock rise");

  a_latch_steady: assert property (!cs_rise && !clr |=> $stable(latch))
    else $error("latch changed without select rise");

  a_latch_copy: assert property (cs_rise && !clr |=> latch == $past(shift))
    else $error("latch did not copy the shift register");

  a_cs_high_ignore: assert property (pins.cs_n && !clr |=> $stable(shift))
    else $error("shift register moved while select high");

  a_dout_holds: assert property (pins.cs_n && !clr |=> $stable(DOUT))
    else $error("serial output moved while select high");

  a_dout_on_fall: assert property (sclk_fall && !clr |=>
    DOUT == $past(shift[7]))
    else $error("serial output not last stage after falling edge");

  a_pin_clear: assert property (clr |=> shift == 8'h00 && latch == 8'h00 ##1
    SWITCH_CLOSED == 8'h00 || !$past(clr))
    else $error("reset pin did not clear register and switches");

  a_power_up: assert property ($past(SYS_RST) |-> latch == 8'h00 && shift == 8'h00)
    else $error("state not cleared after power-up");

  a_switch_map: assert property (1'b1 |=>
    SWITCH_CLOSED == map_switches($past(latch), $past(ctrl.dual)))
    else $error("switch outputs do not follow the latch");

  a_dout_fall_only: assert property (!sclk_fall && !clr |=> $stable(DOUT))
    else $error("serial output moved without a falling edge");

  a_shift_needs_rise: assert property (!sclk_rise && !clr |=> $stable(shift))
    else $error("shift register moved without a clock rise");

  a_msb_first: assert property (sclk_rise && !clr |=>
    shift[7:1] == $past(shift[6:0]))
    else $error("first-shifted bit did not move toward the output");

  a_switches_steady: assert property (
    $stable(latch) && $stable(ctrl) |=> $stable(SWITCH_CLOSED))
    else $error("switches moved while the latch stood");

  a_last_eight: assert property (cs_rise && rise_count > 4'h8 && !clr |=>
    latch == $past(shift))
    else $error("long frame did not latch the last eight bits");

  a_clear_wins: assert property (clr |=>
    shift == 8'h00 && latch == 8'h00 && DOUT == 1'h0)
    else $error("reset pin did not win over shifting");

  a_clear_switches: assert property ($past(clr, 2) && $past(clr) |->
    SWITCH_CLOSED == 8'h00)
    else $error("switches not open while reset pin held");

  a_power_switches: assert property ($past(SYS_RST) |-> SWITCH_CLOSED == 8'h00)
    else $error("switches not open after power-up");

  // Each switch bit is checked on its own, so no bit can lean on another
  for (genvar b = 0; b < `SSC_WORD_BITS; b++) begin : g_switch_chk
    a_switch_bit: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      !ctrl.dual |=> SWITCH_CLOSED[b] == $past(latch[b]))
      else $error("switch bit does not follow its latch bit");
  end

  a_first_bank: assert property (ctrl.dual |=>
    SWITCH_CLOSED[3:0] == $past(latch[3:0]))
    else $error("first bank does not follow the last four bits");

  a_second_bank: assert property (ctrl.dual |=>
    SWITCH_CLOSED[7:4] == {$past(latch[4]), $past(latch[5]), $past(latch[6]), $past(latch[7])})
    else $error("second bank does not follow the first four bits");

  a_read_stands: assert property (!setup_phase |=> $stable(PRDATA))
    else $error("read data changed outside a setup cycle");

  a_error_unmapped: assert property (setup_phase && !reg_mapped(PADDR) |=> PSLVERR)
    else $error("unmapped access gave no error");

  a_error_cleared: assert property (!PSEL |=> !PSLVERR)
    else $error("error flag stayed up while idle");

  a_ctrl_write: assert property (access_phase && PWRITE && PADDR == `SSC_CTRL_OFF |=>
    ctrl.dual == $past(PWDATA[`SSC_CTRL_DUAL]))
    else $error("control write did not land");

  a_ro_ignored: assert property (access_phase && PWRITE && PADDR != `SSC_CTRL_OFF |=>
    $stable(ctrl))
    else $error("write to a read-only address changed control");

  a_read_shift: assert property (setup_phase && PADDR == `SSC_SHIFT_OFF |=>
    PRDATA == {24'h00_0000, $past(shift)})
    else $error("shift register read wrong");

  a_read_latch: assert property (setup_phase && PADDR == `SSC_LATCH_OFF |=>
    PRDATA == {24'h00_0000, $past(latch)})
    else $error("latch read wrong");

  a_read_ctrl: assert property (setup_phase && PADDR == `SSC_CTRL_OFF |=>
    PRDATA == {31'h0000_0000, $past(ctrl.dual)})
    else $error("control read wrong");

  c_word_latched: cover property (cs_rise && shift == 8'hA5);
  c_long_frame:   cover property (cs_rise && rise_count > 4'h8);
  c_pin_reset:    cover property (clr && latch != 8'h00);
  c_dual_all:     cover property (ctrl.dual && SWITCH_CLOSED == 8'hFF);
  c_apb_error:    cover property (access_phase && PSLVERR);

endmodule

// file: tb/ssc_master.sv
/*
  Serial master model facing the switch shifter pins.
  Assumes tasks are entered just after a rising CLOCK edge.
*/
`timescale 1ns/100ps
module ssc_master (
  input  wire logic CLOCK,
  output      logic CS_N,
  output      logic SCLK,
  output      logic DIN
);
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    DIN  = 1'b0;
  end

  // A sel of 1 keeps select high, so the pins toggle as noise
  task automatic frame(input logic [15:0] w, input int n, input logic sel);
    CS_N <= sel;
    repeat (4) @(posedge CLOCK);
    for (int i = n - 1; i >= 0; i--) begin
      DIN <= w[i];
      repeat (4) @(posedge CLOCK);
      SCLK <= 1'b1;
      repeat (4) @(posedge CLOCK);
      SCLK <= 1'b0;
    end
    repeat (4) @(posedge CLOCK);
    CS_N <= 1'b1;
    // Released data line flips so a stale level cannot pass
    DIN  <= ~DIN;
    repeat (8) @(posedge CLOCK);
  endtask
endmodule

// file: tb/tb_serial_switch_control_shifter.sv
/*
  Self-checking bench for the switch shifter.
  Assumes the APB slave answers whenever PREADY comes.
*/
`timescale 1ns/100ps
`include "ssc_consts.svh"
module tb_serial_switch_control_shifter;
  typedef struct {
    logic        dual;
    int          n;
    logic [15:0] w;
    logic [7:0]  sw;
    logic        dout;
  } ssc_row_type;

  logic        clock   = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reset_n = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, cs_n, sclk, din, dout;
  logic [7:0]  sw, prev;
  int          mismatches = 0;
  int          num_checks = 0;
  ssc_row_type rows [8] = '{
    '{1'b0, 8, 16'h00FF, 8'hFF, 1'b1},
    '{1'b0, 8, 16'h00A5, 8'hA5, 1'b1},
    '{1'b0, 8, 16'h005A, 8'h5A, 1'b0},
    '{1'b0, 4, 16'h000A, 8'hAA, 1'b1},
    '{1'b0, 12, 16'h03C5, 8'hC5, 1'b1},
    '{1'b1, 8, 16'h0081, 8'h11, 1'b1},
    '{1'b1, 8, 16'h00E2, 8'h72, 1'b1},
    '{1'b0, 8, 16'h0000, 8'h00, 1'b0}};

  ssc_master m (.CLOCK(clock), .CS_N(cs_n), .SCLK(sclk), .DIN(din));
  ssc_shifter DUT (.CLOCK(clock), .SYS_RST(sys_rst), .CS_N(cs_n), .SCLK(sclk),
    .DIN(din), .RESET_N(reset_n), .DOUT(dout), .SWITCH_CLOSED(sw), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  initial forever #20 clock = ~clock;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("reset switches", 8'h00, sw);
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    prev = 8'h00;
    foreach (rows[i]) begin
      fork
        m.frame(rows[i].w, rows[i].n, 1'b0);
        begin
          // Mid-shift: the old switch state must stand
          repeat (30) @(posedge clock);
          chk("held switches", prev, sw);
        end
      join
      apb(1'b1, `SSC_CTRL_OFF, {31'h0, rows[i].dual}, rd, err);
      apb(1'b0, `SSC_LATCH_OFF, 32'h0, rd, err);
      chk("latch", rows[i].dual ? rows[i].w[7:0] : rows[i].sw, rd[7:0]);
      chk("switches", rows[i].sw, sw);
      chk("serial out", rows[i].dout, dout);
      prev = rows[i].sw;
    end
    m.frame(16'h00FF, 8, 1'b1);
    apb(1'b0, `SSC_SHIFT_OFF, 32'h0, rd, err);
    chk("shift while idle", 32'h0, rd);
    chk("switches while idle", 8'h00, sw);
    m.frame(16'h00C3, 8, 1'b0);
    chk("switches before reset", 8'hC3, sw);
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("switches after reset", 8'h00, sw);
    apb(1'b0, `SSC_SHIFT_OFF, 32'h0, rd, err);
    chk("shift after reset", 32'h0, rd);
    // Fast stepping: one bit per select pulse walks the closed switch up
    m.frame(16'h0001, 1, 1'b0);
    chk("step switches", 8'h01, sw);
    for (int k = 1; k < 8; k++) begin
      m.frame(16'h0000, 1, 1'b0);
      chk("step switches", 32'h1 << k, sw);
    end
    give_verdict;
  end
endmodule
